/* File: pkg/sfpt_defines.svh */
`ifndef SFPT_DEFINES_SVH
`define SFPT_DEFINES_SVH

// ----------------------------------------------------------------------
// relative byte offsets inside the parameter
// ----------------------------------------------------------------------
`define SFPT_OFS_ID      8'h00
`define SFPT_OFS_LEN     8'h01
`define SFPT_OFS_WRCTL   8'h02
`define SFPT_OFS_ERS4K   8'h03
`define SFPT_OFS_RDMODES 8'h04
`define SFPT_OFS_DW1TOP  8'h05
`define SFPT_OFS_DENS0   8'h06
`define SFPT_OFS_DENS1   8'h07
`define SFPT_OFS_DENS2   8'h08
`define SFPT_OFS_DENS3   8'h09
`define SFPT_OFS_QIO_CYC 8'h0a
`define SFPT_OFS_QIO_OP  8'h0b
`define SFPT_OFS_QO_CYC  8'h0c
`define SFPT_OFS_QO_OP   8'h0d
`define SFPT_OFS_DO_CYC  8'h0e
`define SFPT_OFS_DO_OP   8'h0f
`define SFPT_OFS_DIO_CYC 8'h10
`define SFPT_OFS_DIO_OP  8'h11
`define SFPT_OFS_LAST    8'h11

// ----------------------------------------------------------------------
// byte contents
// ----------------------------------------------------------------------
`define SFPT_VAL_ID      8'ha5
`define SFPT_VAL_LEN     8'h3c
`define SFPT_VAL_WRCTL   8'hff
`define SFPT_VAL_ERS4K   8'hff
`define SFPT_VAL_RDMODES 8'hf3
`define SFPT_VAL_DW1TOP  8'hff
`define SFPT_VAL_DENS0   8'hff
`define SFPT_VAL_DENS1   8'hff
`define SFPT_VAL_DENS2   8'hff
`define SFPT_VAL_DENS3   8'h07
`define SFPT_VAL_QIO_CYC 8'h44
`define SFPT_VAL_QIO_OP  8'heb
`define SFPT_VAL_QO_CYC  8'h08
`define SFPT_VAL_QO_OP   8'h6b
`define SFPT_VAL_DO_CYC  8'h08
`define SFPT_VAL_DO_OP   8'h3b
`define SFPT_VAL_DIO_CYC 8'h80
`define SFPT_VAL_DIO_OP  8'hbb
`define SFPT_VAL_MISS    8'hff

// ----------------------------------------------------------------------
// field positions, reset values, steps
// ----------------------------------------------------------------------
`define SFPT_DDR_BIT     3
`define SFPT_RST_BYTE    8'h00
`define SFPT_PTR_STEP    8'h01

`endif

/* File: pkg/sfpt_pkg.sv */
package sfpt_pkg;

  // one table byte
  typedef logic [7:0] sfpt_byte_t;

  // read session state
  typedef enum logic [1:0]
  {
    SFPT_ST_IDLE  = 2'b00,
    SFPT_ST_SERVE = 2'b01
  } sfpt_state_t;

endpackage

/* File: verilog/sfpt_rom.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sfpt_defines.svh"

module sfpt_rom
(
  input  wire logic                 i_addr_hit_unused_n,
  input  wire sfpt_pkg::sfpt_byte_t i_addr,
  output logic                      o_hit,
  output sfpt_pkg::sfpt_byte_t      o_data
);

  // ----------------------------------------------------------------------
  // constant lookup
  // ----------------------------------------------------------------------

  // returns the fixed byte for a relative offset, erased value elsewhere
  function automatic sfpt_pkg::sfpt_byte_t sfpt_lookup
  (
    input sfpt_pkg::sfpt_byte_t addr
  );
    sfpt_pkg::sfpt_byte_t val;
    begin
      val = `SFPT_VAL_MISS;
      unique case (addr)
        // (RQ1) identifier byte
        `SFPT_OFS_ID:      val = `SFPT_VAL_ID;
        // (RQ2) length byte
        `SFPT_OFS_LEN:     val = `SFPT_VAL_LEN;
        // (RQ3) write control byte
        `SFPT_OFS_WRCTL:   val = `SFPT_VAL_WRCTL;
        // (RQ4) no small erase
        `SFPT_OFS_ERS4K:   val = `SFPT_VAL_ERS4K;
        // (RQ5) (RQ6) read modes, rate flag
        `SFPT_OFS_RDMODES: val = `SFPT_VAL_RDMODES;
        // (RQ12) unused top byte
        `SFPT_OFS_DW1TOP:  val = `SFPT_VAL_DW1TOP;
        // (RQ7) zero based density
        `SFPT_OFS_DENS0:   val = `SFPT_VAL_DENS0;
        `SFPT_OFS_DENS1:   val = `SFPT_VAL_DENS1;
        `SFPT_OFS_DENS2:   val = `SFPT_VAL_DENS2;
        `SFPT_OFS_DENS3:   val = `SFPT_VAL_DENS3;
        // (RQ8) quad I/O entry
        `SFPT_OFS_QIO_CYC: val = `SFPT_VAL_QIO_CYC;
        `SFPT_OFS_QIO_OP:  val = `SFPT_VAL_QIO_OP;
        // (RQ9) quad output entry
        `SFPT_OFS_QO_CYC:  val = `SFPT_VAL_QO_CYC;
        `SFPT_OFS_QO_OP:   val = `SFPT_VAL_QO_OP;
        // (RQ10) dual output entry
        `SFPT_OFS_DO_CYC:  val = `SFPT_VAL_DO_CYC;
        `SFPT_OFS_DO_OP:   val = `SFPT_VAL_DO_OP;
        // (RQ11) dual I/O entry
        `SFPT_OFS_DIO_CYC: val = `SFPT_VAL_DIO_CYC;
        `SFPT_OFS_DIO_OP:  val = `SFPT_VAL_DIO_OP;
        default:           val = `SFPT_VAL_MISS;
      endcase
      sfpt_lookup = val;
    end
  endfunction

  // table byte and in-range flag for the addressed offset
  assign o_data = sfpt_lookup(i_addr);
  assign o_hit  = (i_addr <= `SFPT_OFS_LAST) & ~i_addr_hit_unused_n;

endmodule

`default_nettype wire

/* File: verilog/sfpt_table.sv */
// Functional notes
// (RQ1) byte 00h returns identifier A5h
// (RQ2) byte 01h returns length 3Ch
// (RQ3) byte 02h returns write/erase control FFh
// (RQ4) byte 03h FFh: no 4 kB erase opcode
// (RQ5) byte 04h F3h: read modes, address bytes
// (RQ6) double-rate flag bit 19 reads zero
// (RQ7) bytes 06h-09h: density FFh FFh FFh 07h
// (RQ8) quad-I/O: 44h then opcode EBh
// (RQ9) quad-output: 08h then opcode 6Bh
// (RQ10) dual-output: 08h then opcode 3Bh
// (RQ11) dual-I/O: 80h then opcode BBh
// (RQ12) byte 05h returns FFh
// (RQ13) constant bytes, writes ignored, no read effects
`timescale 1ns/1ps
`default_nettype none
`include "sfpt_defines.svh"

module sfpt_table
(
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_reset,
  input  wire logic                 i_rd_req,
  input  wire sfpt_pkg::sfpt_byte_t i_rd_addr,
  input  wire logic                 i_rd_next,
  input  wire logic                 i_wr_req,
  output logic                      o_rd_valid,
  output sfpt_pkg::sfpt_byte_t      o_rd_data,
  output sfpt_pkg::sfpt_byte_t      o_rd_addr,
  output logic                      o_in_table,
  output logic                      o_wr_ignored
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  sfpt_pkg::sfpt_state_t state;
  sfpt_pkg::sfpt_state_t next_state;
  sfpt_pkg::sfpt_byte_t  ptr;
  sfpt_pkg::sfpt_byte_t  next_ptr;
  sfpt_pkg::sfpt_byte_t  rd_data;
  sfpt_pkg::sfpt_byte_t  next_rd_data;
  logic                  rd_valid;
  logic                  next_rd_valid;
  logic                  in_table;
  logic                  next_in_table;
  logic                  wr_ignored;
  logic                  next_wr_ignored;
  logic                  step;
  logic                  rom_hit;
  sfpt_pkg::sfpt_byte_t  rom_data;

  // ----------------------------------------------------------------------
  // pointer update
  // ----------------------------------------------------------------------

  // a new request reloads the pointer, next advances it inside a session
  always_comb
  begin
    next_state = state;
    next_ptr   = ptr;
    step       = 1'b0;
    unique case (state)
      sfpt_pkg::SFPT_ST_IDLE:
      begin
        if (i_rd_req)
        begin
          next_state = sfpt_pkg::SFPT_ST_SERVE;
          next_ptr   = i_rd_addr;
          step       = 1'b1;
        end
      end
      sfpt_pkg::SFPT_ST_SERVE:
      begin
        if (i_rd_req)
        begin
          next_ptr = i_rd_addr;
          step     = 1'b1;
        end
        else if (i_rd_next)
        begin
          next_ptr = sfpt_pkg::sfpt_byte_t'(ptr + `SFPT_PTR_STEP);
          step     = 1'b1;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // constant table
  // ----------------------------------------------------------------------

  // looked up at the pointer's next value so data lands with it
  sfpt_rom u_rom
  (
    .i_addr_hit_unused_n (1'b0),
    .i_addr              (next_ptr),
    .o_hit               (rom_hit),
    .o_data              (rom_data)
  );

  // ----------------------------------------------------------------------
  // answer path
  // ----------------------------------------------------------------------

  // (RQ13) reads only, writes ignored
  always_comb
  begin
    next_rd_valid   = step;
    next_rd_data    = rd_data;
    next_in_table   = in_table;
    next_wr_ignored = i_wr_req;
    if (step)
    begin
      next_rd_data  = rom_data;
      next_in_table = rom_hit;
    end
  end

  // registers all state and outputs
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      state      <= sfpt_pkg::SFPT_ST_IDLE;
      ptr        <= `SFPT_RST_BYTE;
      rd_data    <= `SFPT_RST_BYTE;
      rd_valid   <= 1'b0;
      in_table   <= 1'b0;
      wr_ignored <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      ptr        <= next_ptr;
      rd_data    <= next_rd_data;
      rd_valid   <= next_rd_valid;
      in_table   <= next_in_table;
      wr_ignored <= next_wr_ignored;
    end
  end

  assign o_rd_valid   = rd_valid;
  assign o_rd_data    = rd_data;
  assign o_rd_addr    = ptr;
  assign o_in_table   = in_table;
  assign o_wr_ignored = wr_ignored;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking sfpt_cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);

  // (RQ1) identifier byte
  chk_id_byte: assert property ( // RQ1
    i_rd_req && i_rd_addr == `SFPT_OFS_ID
    |=> o_rd_valid && o_rd_data == `SFPT_VAL_ID)
    else $error("identifier byte wrong");

  // (RQ2) length byte
  chk_len_byte: assert property ( // RQ2
    o_rd_valid && o_rd_addr == `SFPT_OFS_LEN
    |-> o_rd_data == `SFPT_VAL_LEN)
    else $error("length byte wrong");

  // (RQ3) write control byte
  chk_wrctl_byte: assert property ( // RQ3
    o_rd_valid && o_rd_addr == `SFPT_OFS_WRCTL
    |-> o_rd_data == `SFPT_VAL_WRCTL)
    else $error("write control byte wrong");

  // (RQ4) no small erase opcode
  chk_ers4k_byte: assert property ( // RQ4
    o_rd_valid && o_rd_addr == `SFPT_OFS_ERS4K
    |-> o_rd_data == `SFPT_VAL_ERS4K)
    else $error("erase opcode byte wrong");

  // (RQ5) read modes byte, reached by stepping
  chk_modes_step: assert property ( // RQ5
    i_rd_req && i_rd_addr == `SFPT_OFS_ERS4K ##1 i_rd_next && !i_rd_req
    |=> o_rd_valid && o_rd_data == `SFPT_VAL_RDMODES)
    else $error("read modes byte wrong");

  // (RQ6) double rate flag cleared
  chk_ddr_clear: assert property ( // RQ6
    o_rd_valid && o_rd_addr == `SFPT_OFS_RDMODES
    |-> !o_rd_data[`SFPT_DDR_BIT])
    else $error("double rate flag set");

  // (RQ7) density top byte
  chk_dens_top: assert property ( // RQ7
    o_rd_valid && o_rd_addr == `SFPT_OFS_DENS3
    |-> o_rd_data == `SFPT_VAL_DENS3)
    else $error("density top byte wrong");

  // (RQ7) density low bytes
  chk_dens_low: assert property ( // RQ7
    o_rd_valid && o_rd_addr >= `SFPT_OFS_DENS0
    && o_rd_addr <= `SFPT_OFS_DENS2
    |-> o_rd_data == `SFPT_VAL_DENS0)
    else $error("density low byte wrong");

  // (RQ8) quad I/O cycles then opcode
  chk_qio_pair: assert property ( // RQ8
    o_rd_valid && o_rd_addr == `SFPT_OFS_QIO_CYC
    && i_rd_next && !i_rd_req
    |-> o_rd_data == `SFPT_VAL_QIO_CYC
    ##1 o_rd_valid && o_rd_data == `SFPT_VAL_QIO_OP)
    else $error("quad io entry wrong");

  // (RQ9) quad output entry
  chk_qo_entry: assert property ( // RQ9
    o_rd_valid && (o_rd_addr == `SFPT_OFS_QO_CYC
    || o_rd_addr == `SFPT_OFS_QO_OP)
    |-> o_rd_data == ((o_rd_addr == `SFPT_OFS_QO_CYC) ?
                      `SFPT_VAL_QO_CYC : `SFPT_VAL_QO_OP))
    else $error("quad out entry wrong");

  // (RQ10) dual output entry
  chk_do_entry: assert property ( // RQ10
    o_rd_valid && (o_rd_addr == `SFPT_OFS_DO_CYC
    || o_rd_addr == `SFPT_OFS_DO_OP)
    |-> o_rd_data == ((o_rd_addr == `SFPT_OFS_DO_CYC) ?
                      `SFPT_VAL_DO_CYC : `SFPT_VAL_DO_OP))
    else $error("dual out entry wrong");

  // (RQ11) dual I/O entry
  chk_dio_entry: assert property ( // RQ11
    o_rd_valid && (o_rd_addr == `SFPT_OFS_DIO_CYC
    || o_rd_addr == `SFPT_OFS_DIO_OP)
    |-> o_rd_data == ((o_rd_addr == `SFPT_OFS_DIO_CYC) ?
                      `SFPT_VAL_DIO_CYC : `SFPT_VAL_DIO_OP))
    else $error("dual io entry wrong");

  // (RQ12) upper doubleword byte
  chk_dw1_top: assert property ( // RQ12
    o_rd_valid && o_rd_addr == `SFPT_OFS_DW1TOP
    |-> o_rd_data == `SFPT_VAL_DW1TOP)
    else $error("upper byte wrong");

  // (RQ13) writes leave the answer alone
  chk_wr_inert: assert property ( // RQ13
    i_wr_req && !i_rd_req && !i_rd_next
    |=> $stable(o_rd_data) && !o_rd_valid && o_wr_ignored)
    else $error("write changed table answer");

  // (RQ13) same offset always reads the same byte
  chk_repeat_same: assert property ( // RQ13
    i_rd_req ##1 i_rd_req && i_rd_addr == $past(i_rd_addr)
    |=> $stable(o_rd_data))
    else $error("repeat read differs");

  // main scenarios
  cov_id_read:    cover property (i_rd_req && i_rd_addr == `SFPT_OFS_ID);
  cov_step_run:   cover property ((o_rd_valid && i_rd_next) [*4]);
  cov_past_end:   cover property (o_rd_valid && !o_in_table);
  cov_wr_ignored: cover property (o_wr_ignored);

endmodule

`default_nettype wire

/* File: tb/sfpt_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module sfpt_host_model
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rd_valid,
  input  wire logic [7:0] i_rd_data,
  input  wire logic [7:0] i_rd_addr,
  output logic            o_rd_req,
  output logic            o_rd_next,
  output logic [7:0]      o_rd_addr,
  output logic            o_wr_req,
  output logic [7:0]      o_next_param,
  output logic            o_ddr_used
);
  // ----------------------------------------------------------------
  // request driving
  // ----------------------------------------------------------------
  // idle levels from time zero
  initial
  begin
    o_rd_req     = 1'b0;
    o_rd_next    = 1'b0;
    o_rd_addr    = 8'h00;
    o_wr_req     = 1'b0;
    o_next_param = 8'h00;
    o_ddr_used   = 1'b0;
  end

  // one request cycle, launched just after a rising edge
  task automatic drive(input logic req, input logic nxt,
                       input logic [7:0] a, input logic w);
    @(posedge i_ref_clk);
    o_rd_req  <= req;
    o_rd_next <= nxt;
    o_rd_addr <= a;
    o_wr_req  <= w;
  endtask

  // ----------------------------------------------------------------
  // table use on the host side
  // ----------------------------------------------------------------
  // next parameter, rate
  always @(posedge i_ref_clk)
  begin
    if (i_rd_valid === 1'b1 && i_rd_addr === 8'h01)
      o_next_param <= 8'h01 + i_rd_data + 8'h01;
    if (i_rd_valid === 1'b1 && i_rd_addr === 8'h04)
      o_ddr_used <= i_rd_data[3]; // single rate when clear
  end
endmodule

`default_nettype wire

/* File: tb/sfpt_table_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module sfpt_table_tb;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 rd_req;
  logic                 rd_next;
  logic                 wr_req;
  sfpt_pkg::sfpt_byte_t rd_addr;
  logic                 o_valid;
  sfpt_pkg::sfpt_byte_t o_data;
  sfpt_pkg::sfpt_byte_t o_addr;
  logic                 o_in;
  logic                 o_wr;
  logic [7:0]           next_param;
  logic                 ddr_used;
  logic [16:0]          exp_q[$];
  logic [7:0]           ptr = 8'h00;
  logic                 started = 1'b0;
  logic [31:0]          r;
  integer               seed = 32'h37680185;
  integer               n_mismatch = 0;
  integer               n_tests = 0;
  integer               n_wr_sent = 0;
  integer               n_wr_seen = 0;
  localparam logic [7:0] TBL [0:17] = '{8'ha5, 8'h3c, 8'hff, 8'hff,
    8'hf3, 8'hff, 8'hff, 8'hff, 8'hff, 8'h07, 8'h44, 8'heb, 8'h08,
    8'h6b, 8'h08, 8'h3b, 8'h80, 8'hbb};

  // 25 MHz clock
  always #20 clk = ~clk;

  sfpt_table u_dut (.i_ref_clk(clk), .i_reset(rst), .i_rd_req(rd_req),
    .i_rd_addr(rd_addr), .i_rd_next(rd_next), .i_wr_req(wr_req),
    .o_rd_valid(o_valid), .o_rd_data(o_data), .o_rd_addr(o_addr),
    .o_in_table(o_in), .o_wr_ignored(o_wr));

  sfpt_host_model u_host (.i_ref_clk(clk), .i_rd_valid(o_valid),
    .i_rd_data(o_data), .i_rd_addr(o_addr), .o_rd_req(rd_req),
    .o_rd_next(rd_next), .o_rd_addr(rd_addr), .o_wr_req(wr_req),
    .o_next_param(next_param), .o_ddr_used(ddr_used));

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one request, noting the expected answer
  task automatic op(input logic req, input logic nxt,
                    input logic [7:0] a, input logic w);
    u_host.drive(req, nxt, a, w);
    if (req || (nxt && started))
    begin
      ptr = req ? a : ptr + 8'h01;
      exp_q.push_back((ptr <= 8'h11) ? {1'b1, ptr, TBL[ptr[4:0]]}
                                      : {1'b0, ptr, 8'hff});
    end
    started = started | req;
    if (w)
      n_wr_sent = n_wr_sent + 1;
  endtask

  // bounded wait for all answers
  task automatic drain;
    integer i;
    for (i = 0; i < 20 && exp_q.size() != 0; i = i + 1)
      @(posedge clk);
    repeat (2) @(posedge clk);
    @(negedge clk);
    if (exp_q.size() != 0)
    begin
      n_mismatch = n_mismatch + 1;
      complete_run();
    end
  endtask

  // ----------------------------------------------------------------
  // output watcher
  // ----------------------------------------------------------------
  // answered bytes
  always @(negedge clk)
  begin
    if (o_wr === 1'b1)
      n_wr_seen = n_wr_seen + 1;
    if (o_valid === 1'b1 && exp_q.size() == 0)
      chk({o_in, o_addr, o_data}, 17'h1ffff);
    else if (o_valid === 1'b1)
      chk({o_in, o_addr, o_data}, exp_q.pop_front());
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // step before any start is refused
    op(1'b0, 1'b1, 8'h00, 1'b0);
    op(1'b0, 1'b0, 8'h00, 1'b0);
    drain();
    chk({o_in, o_data}, 17'h0);
    // whole table back to back, then past the end
    op(1'b1, 1'b0, 8'h00, 1'b0);
    repeat (19) op(1'b0, 1'b1, 8'h00, 1'b0);
    // wrap from the top offset
    op(1'b1, 1'b0, 8'hff, 1'b1);
    op(1'b0, 1'b1, 8'h00, 1'b1);
    // random reads, steps and writes
    repeat (60)
    begin
      r = $random(seed);
      op(r[8], r[10], {3'b000, r[4:0]} | {r[7:5] & {3{r[9]}}, 5'h00}, r[11]);
    end
    // step from the erase byte, write alone, repeated read
    op(1'b1, 1'b0, 8'h03, 1'b0);
    op(1'b0, 1'b1, 8'h00, 1'b0);
    op(1'b0, 1'b0, 8'h00, 1'b1);
    op(1'b1, 1'b0, 8'h01, 1'b0);
    op(1'b1, 1'b0, 8'h04, 1'b0);
    op(1'b1, 1'b0, 8'h04, 1'b0);
    op(1'b0, 1'b0, 8'h00, 1'b0);
    drain();
    chk({9'h0, next_param}, 17'h3e);
    chk({16'h0, ddr_used}, 17'h0);
    chk(n_wr_seen[16:0], n_wr_sent[16:0]);
    // reset in mid-run, then refused step again
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    started = 1'b0;
    @(negedge clk);
    chk({o_in, o_addr, o_data}, 17'h0);
    op(1'b0, 1'b1, 8'h00, 1'b0);
    op(1'b1, 1'b0, 8'h0a, 1'b0);
    op(1'b0, 1'b1, 8'h00, 1'b0);
    op(1'b0, 1'b0, 8'h00, 1'b0);
    drain();
    complete_run();
  end
endmodule

`default_nettype wire
